// File: twr_bus_peer.sv
// Far-side bus peer: open-drain wiring, stuck data line and framing traffic
module twr_bus_peer (
   // Clock
   input wire logic clk_i,
   // Design pull-downs
   input wire logic scl_oe_i,
   input wire logic sda_oe_i,
   // Resolved lines
   output logic scl_o,
   output logic sda_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic scl_low = 1'b0;
   logic sda_low = 1'b0;
   int pulses = 0;
   // Pull-ups: a released line reads high
   assign scl_o = ~(scl_oe_i | scl_low);
   assign sda_o = ~(sda_oe_i | sda_low);
   always @(negedge scl_o) begin
      pulses++;
   end
   // Half of the 800 ns link period
   task automatic half();
      repeat (4) @(posedge clk_i);
   endtask
   task automatic start();
      half();
      sda_low <= 1'b1;
      half();
   endtask
   // Data held low until n clock rises, let go while clock low
   task automatic stuck(input int n);
      pulses = 0;
      sda_low <= 1'b1;
      repeat (n) @(posedge scl_o);
      @(negedge scl_o);
      sda_low <= 1'b0;
   endtask
   // Four clock pulses, data pulled low in the last, then STOP; clock always let go at the end
   task automatic frame(input logic with_start);
      if (with_start) begin
         start();
      end
      repeat (3) begin
         scl_low <= 1'b1;
         half();
         scl_low <= 1'b0;
         half();
      end
      scl_low <= 1'b1;
      sda_low <= 1'b1;
      half();
      scl_low <= 1'b0;
      half();
      sda_low <= 1'b0;
      half();
   endtask
endmodule

// File: twr_cfg.svh
// Offsets, field positions, reset values and timing counts of the recovery block
`ifndef TWR_CFG_SVH
`define TWR_CFG_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define TWR_CTRL_OFS 8'h00
`define TWR_STAT_OFS 8'h04
`define TWR_IRQS_OFS 8'h08
`define TWR_IRQM_OFS 8'h0C
// ****************************************
// Field positions and reset values
// ****************************************
`define TWR_CTRL_START_REQ 0
`define TWR_CTRL_STOP_REQ 1
`define TWR_CTRL_SI 2
`define TWR_CTRL_EN 3
`define TWR_CTRL_RST 4'h0
`define TWR_IRQ_BERR 0
`define TWR_IRQ_START 1
`define TWR_IRQ_RECOV 2
`define TWR_IRQ_RST 3'h0
`define TWR_CODE_START 8'h08
`define TWR_CODE_BERR 8'h00
`define TWR_CODE_NONE 8'hF8
// ****************************************
// Timing
// ****************************************
`define TWR_CLK_NS 100
`define TWR_HALF_NS 5000
`define TWR_HALF_CYC ((`TWR_HALF_NS + `TWR_CLK_NS - 1) / `TWR_CLK_NS)
`define TWR_PULSES_PER_TRY 2
`endif

// File: twr_hang_recovery.sv
// Two-wire serial unit: stuck-line recovery and bus error handling
// Operation
// - Data low at start: send extra clocks
// - Retry START after every two extra clocks
// - Data released: send START, post 08H
// - Same recovery for forced access, repeated START
// - Recovery runs fully in hardware
// - Flag START/STOP at illegal frame position
// - React only as master or addressed slave
// - Bus error: unaddressed, release, flag, 00H
// - Stop request plus flag clear ends error
// - Flag clear: status reads F8H
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`include "twr_cfg.svh"
module twr_hang_recovery
   import twr_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Slave logic on this clock
   input wire logic slave_addressed_i,
   // Open-drain lines
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic scl_oe_o,
   output logic sda_o,
   output logic sda_oe_o,
   // Interrupt
   output logic irq_o
);
   localparam logic [7:0] HALF_LAST = 8'(`TWR_HALF_CYC - 1);
   localparam logic PULSE_LAST = 1'(`TWR_PULSES_PER_TRY - 1);

   // ****************************************
   // Line synchronisers and condition detect
   // ****************************************
   twr_lines_s lines_m, lines_s, lines_q;
   logic start_det, stop_det, scl_rise, scl_fall;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lines_m <= '1;
         lines_s <= '1;
         lines_q <= '1;
      end else begin
         lines_m <= '{scl: scl_i, sda: sda_i};
         lines_s <= lines_m;
         lines_q <= lines_s;
      end
   end

   assign start_det = lines_s.scl && lines_q.scl && lines_q.sda && !lines_s.sda;
   assign stop_det = lines_s.scl && lines_q.scl && !lines_q.sda && lines_s.sda;
   assign scl_rise = lines_s.scl && !lines_q.scl;
   assign scl_fall = !lines_s.scl && lines_q.scl;

   // ****************************************
   // Bit position within byte plus ack slot
   // ****************************************
   logic [3:0] bitpos;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bitpos <= 4'h0;
      end else if (start_det || stop_det) begin
         bitpos <= 4'h0;
      end else if (scl_rise) begin
         bitpos <= bitpos + 4'h1;
      end else if (scl_fall && bitpos == 4'h9) begin
         bitpos <= 4'h0;
      end
   end

   // ****************************************
   // Register file state
   // ****************************************
   twr_state_e state;
   logic start_request_flag, stop_request_flag, si, en;
   logic [7:0] code;
   logic master, busy, err_flag;
   logic [2:0] irq_stat, irq_mask;
   logic [7:0] half_cnt;
   logic pulse_cnt;
   logic acc, ctl_wr, involved, berr, go, forced, err_clear, half_done;
   logic start_posted, recov_begin;
   logic [7:0] stat_rd;

   assign acc = cyc_i && stb_i && ack_o;
   assign ctl_wr = acc && we_i && sel_i[0] && adr_i == `TWR_CTRL_OFS;
   assign involved = master || slave_addressed_i;
   assign half_done = half_cnt == HALF_LAST;
   assign stat_rd = si ? code : `TWR_CODE_NONE;

   // Conditions at bit positions 2..9 cut a byte or ack bit
   assign berr = (start_det || stop_det) && involved && bitpos >= 4'h2
                 && (state == ST_IDLE || state == ST_OWN);
   assign forced = start_request_flag && stop_request_flag && busy && !master
                   && !err_flag;
   assign err_clear = stop_request_flag && !si && !start_request_flag
                      && (err_flag || master);
   assign go = en && start_request_flag && !si && !err_flag && state == ST_IDLE
               && (!busy || master);
   assign start_posted = state == ST_SCLLO && half_done;
   assign recov_begin = state == ST_REL && half_done && !lines_s.sda;

   // ****************************************
   // Wishbone slave
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (cyc_i && stb_i && !ack_o && !we_i) begin
         unique case (adr_i)
            `TWR_CTRL_OFS: dat_o <= {28'h000_0000, en, si, stop_request_flag, start_request_flag};
            `TWR_STAT_OFS: dat_o <= {24'h00_0000, stat_rd};
            `TWR_IRQS_OFS: dat_o <= {29'h0000_0000, irq_stat};
            `TWR_IRQM_OFS: dat_o <= {29'h0000_0000, irq_mask};
            default: dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // Control flags
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {en, si, stop_request_flag, start_request_flag} <= `TWR_CTRL_RST;
      end else begin
         if (ctl_wr) begin
            start_request_flag <= dat_i[`TWR_CTRL_START_REQ];
            en <= dat_i[`TWR_CTRL_EN];
         end
         if (forced || err_clear) begin
            stop_request_flag <= 1'b0;
         end else if (ctl_wr) begin
            stop_request_flag <= dat_i[`TWR_CTRL_STOP_REQ];
         end
         if (berr || start_posted) begin
            si <= 1'b1;
         end else if (ctl_wr) begin
            si <= dat_i[`TWR_CTRL_SI];
         end
      end
   end

   // ****************************************
   // Status code
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         code <= `TWR_CODE_NONE;
      end else if (berr) begin
         code <= `TWR_CODE_BERR;
      end else if (start_posted) begin
         code <= `TWR_CODE_START;
      end else if (!si) begin
         code <= `TWR_CODE_NONE;
      end
   end

   // ****************************************
   // Bus role and busy tracking
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         master <= 1'b0;
         err_flag <= 1'b0;
      end else if (berr) begin
         master <= 1'b0;
         err_flag <= 1'b1;
      end else if (err_clear) begin
         master <= 1'b0;
         err_flag <= 1'b0;
      end else if (start_posted) begin
         master <= 1'b1;
      end else if (stop_det && state == ST_IDLE) begin
         master <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy <= 1'b0;
      end else if (forced || stop_det) begin
         busy <= 1'b0; // Forced access acts as a received STOP
      end else if (start_det) begin
         busy <= 1'b1;
      end
   end

   // ****************************************
   // Recovery and START sequencer
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i || berr || state == ST_IDLE || state == ST_OWN || half_done) begin
         half_cnt <= 8'h00;
      end else if (lines_s.scl || state == ST_PLO || state == ST_SCLLO) begin
         half_cnt <= half_cnt + 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || berr) begin
         state <= ST_IDLE;
         pulse_cnt <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: if (go) begin
               state <= ST_REL;
            end
            ST_REL: if (half_done) begin
               state <= lines_s.sda ? ST_SHOLD : ST_PLO;
               pulse_cnt <= 1'b0;
            end
            ST_PLO: if (half_done) begin
               state <= ST_PHI;
            end
            ST_PHI: if (half_done) begin
               pulse_cnt <= pulse_cnt + 1'b1;
               state <= pulse_cnt == PULSE_LAST ? ST_REL : ST_PLO;
            end
            ST_SHOLD: if (half_done) begin
               state <= ST_SCLLO;
            end
            ST_SCLLO: if (half_done) begin
               state <= ST_OWN;
            end
            ST_OWN: if (!si) begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Open-drain drive: only ever pulls low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   always_ff @(posedge clk_i) begin
      if (rst_i || berr) begin
         scl_oe_o <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         scl_oe_o <= state == ST_PLO || state == ST_SCLLO || state == ST_OWN;
         sda_oe_o <= state == ST_SHOLD || state == ST_SCLLO;
      end
   end

   // ****************************************
   // Interrupt status and mask
   // ****************************************
   logic [2:0] irq_set;
   assign irq_set = {recov_begin, start_posted, berr};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat <= `TWR_IRQ_RST;
      end else if (acc && we_i && sel_i[0] && adr_i == `TWR_IRQS_OFS) begin
         irq_stat <= (irq_stat & ~dat_i[2:0]) | irq_set;
      end else begin
         irq_stat <= irq_stat | irq_set;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask <= `TWR_IRQ_RST;
      end else if (acc && we_i && sel_i[0] && adr_i == `TWR_IRQM_OFS) begin
         irq_mask <= dat_i[2:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   chk_berr_code: assert property (@(posedge clk_i) disable iff (rst_i)
      berr |=> si && code == `TWR_CODE_BERR && !master)
      else $error("bus error did not post 00H");
   chk_berr_release: assert property (@(posedge clk_i) disable iff (rst_i)
      berr |=> !scl_oe_o && !sda_oe_o && state == ST_IDLE)
      else $error("bus error did not release lines");
   chk_none_code: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o && !we_i && adr_i == `TWR_STAT_OFS && !$past(si) |-> dat_o[7:0] == `TWR_CODE_NONE)
      else $error("status not F8H with flag clear");
   chk_berr_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      si && code == `TWR_CODE_BERR && !ctl_wr |=> code == `TWR_CODE_BERR)
      else $error("bus error code changed early");
   chk_pulse_start: assert property (@(posedge clk_i) disable iff (rst_i)
      recov_begin && !berr |=> state == ST_PLO ##1 scl_oe_o)
      else $error("no extra clock on stuck data");
   chk_retry_pair: assert property (@(posedge clk_i) disable iff (rst_i)
      state == ST_PHI && half_done && pulse_cnt && !berr |=> state == ST_REL)
      else $error("no retry after two pulses");
   chk_start_code: assert property (@(posedge clk_i) disable iff (rst_i)
      start_posted && !berr |=> si && code == `TWR_CODE_START && master)
      else $error("START did not post 08H");
   chk_ignore_uninvolved: assert property (@(posedge clk_i) disable iff (rst_i)
      (start_det || stop_det) && !involved |=> !(si && code == `TWR_CODE_BERR && !$past(si)))
      else $error("bus error taken while uninvolved");
   chk_illegal_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (start_det || stop_det) && involved && bitpos == 4'h4 && state == ST_IDLE |=> err_flag)
      else $error("illegal condition not flagged");
   chk_err_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      err_flag && stop_request_flag && !si && !start_request_flag && !berr
      |=> !stop_request_flag && !err_flag && !master)
      else $error("error recovery did not clear stop");
endmodule

// File: twr_hang_recovery_tb_top.sv
// Self-checking bench of the hang recovery and bus error block
`include "twr_cfg.svh"
module twr_hang_recovery_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] C_START = {24'h000000, `TWR_CODE_START};
   localparam logic [31:0] C_BERR = {24'h000000, `TWR_CODE_BERR};
   localparam logic [31:0] C_NONE = {24'h000000, `TWR_CODE_NONE};
   logic clk_i, rst_i, cyc, stb, we, ack, addressed, scl, sda;
   logic scl_oe, sda_oe, irq, scl_lvl, sda_lvl;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat, rdat;
   int fails = 0;
   int n_tests = 0;
   int cycles = 0;
   twr_hang_recovery dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
      .slave_addressed_i(addressed), .scl_i(scl), .sda_i(sda), .scl_o(scl_lvl),
      .scl_oe_o(scl_oe), .sda_o(sda_lvl), .sda_oe_o(sda_oe), .irq_o(irq));
   twr_bus_peer peer (.clk_i(clk_i), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .scl_o(scl),
      .sda_o(sda));
   // ****************************************
   // Clock, timeout and shared tasks
   // ****************************************
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 30000) begin
         fails++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      dat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      wb(a, 1'b0, 32'h0, q);
      chk(nm, e, q);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(a, 1'b1, d, q);
   endtask
   task automatic wait_si();
      logic [31:0] q;
      q = 32'h0;
      while (q[`TWR_CTRL_SI] !== 1'b1) wb(`TWR_CTRL_OFS, 1'b0, 32'h0, q);
   endtask
   task automatic chk_irq(input logic e);
      repeat (2) @(posedge clk_i);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      rd(`TWR_CTRL_OFS, 32'h0, "ctrl");
      rd(`TWR_STAT_OFS, C_NONE, "status");
      rd(`TWR_IRQS_OFS, 32'h0, "irq status");
      rd(8'h10, 32'h0, "unmapped");
      chk("line drive", 32'h0, {28'h0, scl_lvl, sda_lvl, scl_oe, sda_oe});
      $display("test reset done");
   endtask
   // Forced access on a busy bus whose data line is stuck low
   task automatic t_recover();
      wr(`TWR_IRQM_OFS, 32'h07);
      peer.start();
      fork
         peer.stuck(3);
         begin
            wr(`TWR_CTRL_OFS, 32'h0B);
            wait_si();
         end
      join
      chk("pulses", 2 * `TWR_PULSES_PER_TRY + 1, peer.pulses);
      rd(`TWR_STAT_OFS, C_START, "status");
      rd(`TWR_CTRL_OFS, 32'h0D, "ctrl");
      rd(`TWR_IRQS_OFS, 32'h06, "irq status");
      chk_irq(1'b1);
      wr(`TWR_IRQS_OFS, 32'h06);
      chk_irq(1'b0);
      wr(`TWR_CTRL_OFS, 32'h08);
      rd(`TWR_STAT_OFS, C_NONE, "status");
      $display("test recover done");
   endtask
   task automatic t_berr_master();
      peer.frame(1'b0);
      wait_si();
      chk("line drive", 32'h0, {30'h0, scl_oe, sda_oe});
      rd(`TWR_STAT_OFS, C_BERR, "status");
      rd(`TWR_STAT_OFS, C_BERR, "status");
      rd(`TWR_IRQS_OFS, 32'h01, "irq status");
      chk_irq(1'b1);
      wr(`TWR_CTRL_OFS, 32'h0A);
      rd(`TWR_CTRL_OFS, 32'h08, "ctrl");
      rd(`TWR_STAT_OFS, C_NONE, "status");
      wr(`TWR_IRQS_OFS, 32'h01);
      $display("test master bus error done");
   endtask
   task automatic t_slave();
      addressed <= 1'b0;
      peer.frame(1'b1);
      rd(`TWR_CTRL_OFS, 32'h08, "ctrl");
      rd(`TWR_STAT_OFS, C_NONE, "status");
      wr(`TWR_IRQM_OFS, 32'h06);
      addressed <= 1'b1;
      peer.frame(1'b1);
      wait_si();
      rd(`TWR_STAT_OFS, C_BERR, "status");
      chk_irq(1'b0);
      wr(`TWR_IRQM_OFS, 32'h07);
      chk_irq(1'b1);
      addressed <= 1'b0;
      wr(`TWR_CTRL_OFS, 32'h0A);
      wr(`TWR_IRQS_OFS, 32'h01);
      chk_irq(1'b0);
      rd(`TWR_STAT_OFS, C_NONE, "status");
      $display("test slave bus error done");
   endtask
   initial begin
      rst_i = 1'b1;
      {cyc, stb, we, addressed} = 4'h0;
      adr = 8'h00;
      sel = 4'h1;
      dat = 32'h0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_recover();
      t_berr_master();
      t_slave();
      results();
   end
endmodule

// File: twr_pkg.sv
// Types shared by the two-wire hang recovery block
package twr_pkg;
   // ****************************************
   // Sequencer states
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_REL,
      ST_PLO,
      ST_PHI,
      ST_SHOLD,
      ST_SCLLO,
      ST_OWN
   } twr_state_e;
   // ****************************************
   // Line pair carrier
   // ****************************************
   typedef struct packed {
      logic scl;
      logic sda;
   } twr_lines_s;
endpackage
